// [rtl/sector_protect_defines.vh]
// Constants for the sector protection control block
// What this block does
// - Four bytes 3d 2a 7f a9 then chip select high turn software protection on.
// - Four bytes 3d 2a 7f 9a then chip select high turn software protection off.
// - After power-up the software protection latch is off.
// - While write-protect is asserted flagged sectors and the protect table refuse writes.
// - Asserting write-protect turns protection on within the assert delay.
// - Releasing write-protect drops protection within the release delay unless enabled.
// - An enable command before or during write-protect keeps protection after release.
// - The disable command is ignored while write-protect is asserted.
// - Write-protect passes a noise filter so short glitches change nothing.
// - A floating write-protect pin reads as deasserted through its pull-up; the block has no pull-up, its synchroniser only resets high.
// - Write-protect protects sectors but never alters the software latch.
// - Status reports whether protection is on by command or by the pin.
// - Pin high and no enable since power-up reads disabled with the table writable.
// - The protect table holds 64 bytes where ff protects and 00 unprotects a sector.
// - Sector 0 bits 7:6 guard its first subsector and bits 5:4 its second.
`ifndef SECTOR_PROTECT_DEFINES_VH
`define SECTOR_PROTECT_DEFINES_VH

// ==========================================
// Command bytes
`define CMD_BYTE1 8'h3d
`define CMD_BYTE2 8'h2a
`define CMD_BYTE3 8'h7f
`define CMD_ENABLE 8'ha9
`define CMD_DISABLE 8'h9a
`define CMD_BITS 6'h20

// ==========================================
// Protect table layout
`define SPR_BYTES 64
`define SPR_PROT 8'hff
`define SPR_UNPROT 8'h00
`define SPR_RESET 8'h00
`define SUB_A_HI 7
`define SUB_A_LO 6
`define SUB_B_HI 5
`define SUB_B_LO 4

// ==========================================
// Timing
`define CLK_PERIOD_NS 10
`define PROTECT_ASSERT_DELAY_NS 1000
`define PROTECT_RELEASE_DELAY_NS 1000
`define WP_FILTER_NS 200
`define WP_FILTER_CYC ((`WP_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/sector_protect_control.v]
// Sector protection control: command decode, write-protect filter, sector check
`include "sector_protect_defines.vh"
`default_nettype none

module sector_protect_control #(
   parameter FILT_CYC = `WP_FILTER_CYC,
   parameter FILT_W = 8
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire sck_i,
   input wire cs_n_i,
   input wire si_i,
   input wire wp_n_i,
   input wire chk_req_i,
   input wire [5:0] chk_sector_i,
   input wire chk_sub_b_i,
   input wire chk_table_i,
   input wire spr_erase_i,
   input wire spr_wr_i,
   input wire [5:0] spr_wr_idx_i,
   input wire [7:0] spr_wr_data_i,
   input wire [5:0] spr_rd_idx_i,
   output reg chk_done_o,
   output reg chk_blocked_o,
   output reg spr_refused_o,
   output reg [7:0] spr_rd_data_o,
   output reg prot_status_o,
   output reg wp_active_o
);

   // ==========================================
   // Pin synchronisers
   reg sck_s1_q, sck_s2_q, sck_s3_q;
   reg cs_s1_q, cs_s2_q, cs_s3_q;
   reg si_s1_q, si_s2_q;
   reg wp_s1_q, wp_s2_q;

   // Third stage gives the edge detectors a settled previous level
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
      end else begin
         sck_s1_q <= sck_i;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
      end
   end

   // Chip select idles high so reset never fakes a frame end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
      end else begin
         cs_s1_q <= cs_n_i;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         si_s1_q <= 1'b0;
         si_s2_q <= 1'b0;
      end else begin
         si_s1_q <= si_i;
         si_s2_q <= si_s1_q;
      end
   end

   // ==========================================
   // Write-protect synchroniser
   // No pull-up: synchroniser resets high so the pin reads deasserted until its level is sampled
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_s1_q <= 1'b1;
         wp_s2_q <= 1'b1;
      end else begin
         wp_s1_q <= wp_n_i;
         wp_s2_q <= wp_s1_q;
      end
   end

   wire sck_rise = sck_s2_q & ~sck_s3_q;
   wire cs_rise = cs_s2_q & ~cs_s3_q;

   // ==========================================
   // Write-protect noise filter
   // Filter delay stays below both assert and release delays
   reg wp_f_q;
   reg [FILT_W-1:0] filt_cnt_q;
   wire wp_raw = ~wp_s2_q;

   wire filt_done = (wp_raw != wp_f_q) && (filt_cnt_q == FILT_CYC[FILT_W-1:0] - 1'b1);

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_f_q <= 1'b0;
      end else if (filt_done) begin
         wp_f_q <= wp_raw;
      end
   end

   // Any return to the filtered level restarts the count
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt_cnt_q <= {FILT_W{1'b0}};
      end else if ((wp_raw == wp_f_q) || filt_done) begin
         filt_cnt_q <= {FILT_W{1'b0}};
      end else begin
         filt_cnt_q <= filt_cnt_q + 1'b1;
      end
   end

   // ==========================================
   // Serial command capture
   // Only exactly 32 bits in one frame count as a command
   reg [31:0] shift_q;
   reg [5:0] bit_cnt_q;

   // Shift register only moves inside a frame
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_q <= 32'h0;
      end else if (!cs_s2_q && sck_rise) begin
         shift_q <= {shift_q[30:0], si_s2_q};
      end
   end

   // Saturates so an overlong frame can never wrap back to 32 bits
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_q <= 6'h0;
      end else if (cs_s2_q) begin
         bit_cnt_q <= 6'h0;
      end else if (sck_rise && (bit_cnt_q != 6'h3f)) begin
         bit_cnt_q <= bit_cnt_q + 6'h1;
      end
   end

   wire frame_ok = cs_rise && (bit_cnt_q == `CMD_BITS);

   // Prefix and last byte must both match
   function cmd_match;
      input [31:0] word;
      input [7:0] last;
      begin
         cmd_match = (word[31:8] == {`CMD_BYTE1, `CMD_BYTE2, `CMD_BYTE3}) &&
                     (word[7:0] == last);
      end
   endfunction

   wire cmd_en = frame_ok && cmd_match(shift_q, `CMD_ENABLE);
   wire cmd_dis = frame_ok && cmd_match(shift_q, `CMD_DISABLE);

   // ==========================================
   // Software protection latch
   // Pin never writes this latch; it blocks the disable command and adds to the effective state
   reg sw_prot_q;
   reg sw_prot_d;

   // Enable wins; the two decodes never fire together anyway
   always @* begin
      sw_prot_d = sw_prot_q;
      if (cmd_en) begin
         sw_prot_d = 1'b1;
      end else if (cmd_dis && !wp_f_q) begin
         sw_prot_d = 1'b0;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_prot_q <= 1'b0;
      end else begin
         sw_prot_q <= sw_prot_d;
      end
   end

   wire eff_prot = sw_prot_q | wp_f_q;

   // ==========================================
   // Protect table
   reg [7:0] spr_q [0:`SPR_BYTES-1];
   integer i;

   // Table is read-only while the pin is asserted
   wire spr_lock = wp_f_q;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (i = 0; i < `SPR_BYTES; i = i + 1) begin
            spr_q[i] <= `SPR_RESET;
         end
      end else if (!spr_lock) begin
         if (spr_erase_i) begin
            for (i = 0; i < `SPR_BYTES; i = i + 1) begin
               spr_q[i] <= `SPR_PROT;
            end
         end else if (spr_wr_i) begin
            spr_q[spr_wr_idx_i] <= spr_wr_data_i;
         end
      end
   end

   // Sector 0 is split; each half has its own two-bit field
   function sub_flagged;
      input [7:0] val;
      input sub_b;
      begin
         if (sub_b) begin
            sub_flagged = val[`SUB_B_HI:`SUB_B_LO] == 2'b11;
         end else begin
            sub_flagged = val[`SUB_A_HI:`SUB_A_LO] == 2'b11;
         end
      end
   endfunction

   // Invalid byte values count as unprotected outside sector 0, which only looks at its two-bit fields
   function flagged;
      input [7:0] val;
      input [5:0] sec;
      input sub_b;
      begin
         if (sec == 6'h0) begin
            flagged = sub_flagged(val, sub_b);
         end else begin
            flagged = val == `SPR_PROT;
         end
      end
   endfunction

   wire chk_sector_hit = flagged(spr_q[chk_sector_i], chk_sector_i, chk_sub_b_i);
   wire chk_hit = chk_table_i ? spr_lock : (eff_prot && chk_sector_hit);
   // Either table request counts as an attempt, erase or write
   wire spr_try = spr_erase_i | spr_wr_i;

   // ==========================================
   // Registered outputs
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chk_done_o <= 1'b0;
      end else begin
         chk_done_o <= chk_req_i;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chk_blocked_o <= 1'b0;
      end else begin
         chk_blocked_o <= chk_req_i & chk_hit;
      end
   end

   // ==========================================
   // Table port answers
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spr_refused_o <= 1'b0;
      end else begin
         spr_refused_o <= spr_lock & spr_try;
      end
   end

   // Reads are never locked; the table stays readable under the pin
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spr_rd_data_o <= 8'h00;
      end else begin
         spr_rd_data_o <= spr_q[spr_rd_idx_i];
      end
   end

   // ==========================================
   // Status outputs
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prot_status_o <= 1'b0;
      end else begin
         prot_status_o <= eff_prot;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_active_o <= 1'b0;
      end else begin
         wp_active_o <= wp_f_q;
      end
   end

endmodule

`default_nettype wire

// [testbench/sector_protect_control_checker.sv]
// Port assertions for the sector protection control block
`default_nettype none
module sector_protect_control_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wp_n_i,
   input wire logic chk_req_i,
   input wire logic chk_table_i,
   input wire logic spr_erase_i,
   input wire logic spr_wr_i,
   input wire logic chk_done_o,
   input wire logic chk_blocked_o,
   input wire logic spr_refused_o,
   input wire logic prot_status_o,
   input wire logic wp_active_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // Assertions
   req_done_a: assert property (chk_req_i |=> chk_done_o) else $error("no answer");
   idle_done_a: assert property (!chk_req_i |=> !chk_done_o)
      else $error("stray done");
   blk_done_a: assert property (chk_blocked_o |-> chk_done_o)
      else $error("lone block");
   free_chk_a: assert property (
      chk_req_i && !prot_status_o ##1 !prot_status_o |-> !chk_blocked_o)
      else $error("blocked while off");
   tbl_lock_a: assert property (
      chk_req_i && chk_table_i && wp_active_o ##1 wp_active_o |-> chk_blocked_o)
      else $error("table not locked");
   wr_lock_a: assert property (
      (spr_wr_i || spr_erase_i) && wp_active_o ##1 wp_active_o |-> spr_refused_o)
      else $error("write not refused");
   ref_cause_a: assert property (
      spr_refused_o |-> $past(spr_wr_i) || $past(spr_erase_i))
      else $error("stray refusal");
   wp_prot_a: assert property (wp_active_o |-> prot_status_o)
      else $error("pin ignored");
   wp_rise_a: assert property ($rose(wp_active_o) |-> !$past(wp_n_i, 3))
      else $error("rise without pin");
   wp_fall_a: assert property ($fell(wp_active_o) |-> $past(wp_n_i, 3))
      else $error("fall without pin");
   cover property (chk_done_o && chk_blocked_o);
   cover property (spr_refused_o);
   cover property ($fell(wp_active_o) && prot_status_o);
endmodule
bind sector_protect_control sector_protect_control_checker chk (.clk_i, .rst_n_i, .wp_n_i,
   .chk_req_i, .chk_table_i, .spr_erase_i, .spr_wr_i, .chk_done_o, .chk_blocked_o,
   .spr_refused_o, .prot_status_o, .wp_active_o);
`default_nettype wire

// [testbench/host_model.sv]
// Host side model: serial command frames and the write-protect pin
`default_nettype none
module host_model (
   input wire logic clk_i,
   output var logic sck_o,
   output var logic cs_n_o,
   output var logic si_o,
   output var logic wp_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {sck_o, cs_n_o, si_o, wp_n_o} = 4'h7;
   // Four bytes MSB first, then chip select high
   task automatic send(input logic [31:0] w);
      @(negedge clk_i) cs_n_o = 0;
      for (int b = 31; b >= 0; b--) begin
         si_o = w[b];
         repeat (4) @(negedge clk_i);
         sck_o = 1;
         repeat (4) @(negedge clk_i);
         sck_o = 0;
      end
      repeat (4) @(negedge clk_i);
      cs_n_o = 1;
      si_o = !si_o; // Idle line must not echo the last bit
      repeat (4) @(negedge clk_i);
   endtask
   task automatic set_wp(input logic v);
      @(negedge clk_i) wp_n_o = v;
   endtask
   task automatic glitch;
      @(negedge clk_i) wp_n_o = 0;
      @(negedge clk_i) wp_n_o = 1;
   endtask
endmodule
`default_nettype wire

// [testbench/sector_protect_control_tb.sv]
// Self-checking bench for the sector protection control block
`default_nettype none
module sector_protect_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_n_i = 0, chk_req_i = 0, chk_sub_b_i = 0, chk_table_i = 0;
   logic spr_erase_i = 0, spr_wr_i = 0;
   logic [5:0] chk_sector_i = 0, spr_wr_idx_i = 0, spr_rd_idx_i = 0;
   logic [7:0] spr_wr_data_i = 0;
   wire sck_i, cs_n_i, si_i, wp_n_i, chk_done_o, chk_blocked_o, spr_refused_o;
   wire prot_status_o, wp_active_o;
   wire [7:0] spr_rd_data_o;
   int err_total = 0, tests_run = 0, seed = 90, sw = 0, wp = 0;
   logic [7:0] tab [64];
   initial forever #5 clk_i = !clk_i;
   host_model host (.clk_i, .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .wp_n_o(wp_n_i));
   sector_protect_control #(.FILT_CYC(2)) dut (.clk_i, .rst_n_i, .sck_i, .cs_n_i, .si_i, .wp_n_i,
      .chk_req_i, .chk_sector_i, .chk_sub_b_i, .chk_table_i, .spr_erase_i, .spr_wr_i,
      .spr_wr_idx_i, .spr_wr_data_i, .spr_rd_idx_i, .chk_done_o, .chk_blocked_o,
      .spr_refused_o, .spr_rd_data_o, .prot_status_o, .wp_active_o);
   // ==========================================
   // Tasks
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Fixed wait covers sync, filter and latch, well inside the pin delays
   task automatic look;
      repeat (12) @(negedge clk_i);
      cmp("status", sw | wp, prot_status_o);
      cmp("wp", wp, wp_active_o);
   endtask
   task automatic cmd(input logic [31:0] w);
      host.send(w);
      if (w == 32'h3d2a7fa9) sw = 1;
      if (w == 32'h3d2a7f9a && !wp) sw = 0;
      look();
   endtask
   task automatic pin(input logic v);
      host.set_wp(v);
      wp = !v;
      look();
   endtask
   task automatic chk(input int s, input logic b, input logic t);
      logic e;
      @(negedge clk_i) {chk_req_i, chk_sector_i, chk_sub_b_i, chk_table_i} = {1'b1, 6'(s), b, t};
      e = t ? wp : (sw | wp) && (s ? tab[s] == 8'hff : (b ? tab[0][5:4] : tab[0][7:6]) == 2'h3);
      @(negedge clk_i) chk_req_i = 0;
      cmp("done", 1, chk_done_o);
      cmp("blocked", e, chk_blocked_o);
   endtask
   task automatic put(input int x, input logic [7:0] d, input logic er);
      @(negedge clk_i) {spr_wr_i, spr_erase_i, spr_wr_idx_i, spr_wr_data_i} = {!er, er, 6'(x), d};
      @(negedge clk_i) {spr_wr_i, spr_erase_i} = 2'h0;
      cmp("refused", wp, spr_refused_o);
      if (!wp && er) tab = '{default: 8'hff};
      else if (!wp) tab[x] = d;
      @(negedge clk_i) spr_rd_idx_i = 6'(x);
      @(negedge clk_i) cmp("table", tab[x], spr_rd_data_o);
   endtask
   // ==========================================
   // Sequence
   initial begin
      tab = '{default: 8'h00};
      repeat (5) @(negedge clk_i);
      rst_n_i = 1;
      look();
      for (int i = 0; i < 64; i++) put(i, i ? {8{$random(seed) % 2 == 0}} : 8'hc5, 0);
      for (int i = 0; i < 65; i++) chk(i % 64, i == 64, 0);
      $display("test done: table with protection off");
      cmd(32'h3d2a7fcf);
      cmd(32'h3d2a7fa9);
      for (int i = 0; i < 65; i++) chk(i % 64, i == 64, 0);
      cmd(32'h3d2a7f9a);
      $display("test done: commands");
      pin(0);
      put(5, 8'h00, 0);
      put(0, 8'h00, 1);
      chk(0, 0, 1);
      cmd(32'h3d2a7f9a);
      cmd(32'h3d2a7fa9);
      pin(1);
      cmd(32'h3d2a7f9a);
      pin(0);
      pin(1);
      host.glitch();
      look();
      put(0, 8'h00, 1);
      chk(0, 0, 1);
      $display("test done: write-protect pin");
      give_verdict();
   end
   initial begin
      #100us;
      err_total++;
      give_verdict();
   end
endmodule
`default_nettype wire
